// ===== include/ahx_defs.svh
// address map, codes and reset values of the bus fabric
// Notes on behaviour
// - exactly one of processor core or DMA engine owns the bus at any time
// - priority select picks the winner on contention unless a lock or burst holds the owner; core wins after reset
// - only the two masters issue transfers; every other block is a slave
// - two peripheral bridges, narrow and wide, grouped by power domain
// - timer domain blocks (real time clock, second timer) sit behind the wide bridge
// - narrow bridge serves sleep domain slaves and system domain peripherals
// - region below 0x04000000 remaps to boot ROM, OTP or RAM by select
// - 0x07F00000 up to 0x07F24000 selects boot and protocol ROM
// - 0x07F40000 up to 0x07F40100 selects OTP control registers
// - 0x07F80000 up to 0x07F88000 selects the OTP cell array
// - system RAM is one 48 kB window from 0x07FC0000 to 0x07FCC000
// - RAM banks start at 0x07FC0000, 0x07FC4000, 0x07FC7000: 16, 12, 20 kB
// - third RAM bank ends at 0x07FCBFFF
// - link layer at 0x40000000, radio 0x40001000 up to 0x40004000
// - power and clock registers 0x50000000 up to 0x50000100 on narrow bridge
// - wake-up controllers 0x50000100 up to 0x50000200 on narrow bridge
// - quadrature decoder 0x50000200 up to 0x50000300; then reserved to 0x50001000
`ifndef AHX_DEFS_SVH
`define AHX_DEFS_SVH

`define AHX_NUM_SLV    10
`define AHX_ZERO_HI    32'h0400_0000
`define AHX_ROM_LO     32'h07f0_0000
`define AHX_ROM_HI     32'h07f2_4000
`define AHX_OTPR_LO    32'h07f4_0000
`define AHX_OTPR_HI    32'h07f4_0100
`define AHX_OTPC_LO    32'h07f8_0000
`define AHX_OTPC_HI    32'h07f8_8000
`define AHX_RAM1_LO    32'h07fc_0000
`define AHX_RAM2_LO    32'h07fc_4000
`define AHX_RAM3_LO    32'h07fc_7000
`define AHX_RAM3_LAST  32'h07fc_bfff
`define AHX_RAM_HI     32'h07fc_c000
`define AHX_LINK_LO    32'h4000_0000
`define AHX_RADIO_LO   32'h4000_1000
`define AHX_RADIO_HI   32'h4000_4000
`define AHX_PMU_LO     32'h5000_0000
`define AHX_WAKE_LO    32'h5000_0100
`define AHX_QDEC_LO    32'h5000_0200
`define AHX_QDEC_HI    32'h5000_0300
`define AHX_SYSP_LO    32'h5000_1000
`define AHX_SYSP_HI    32'h5000_4000
`define AHX_WIDE_LO    32'h5000_4000
`define AHX_WIDE_HI    32'h5000_4200

`define AHX_REMAP_ROM  2'h0
`define AHX_REMAP_OTP  2'h1
`define AHX_REMAP_RAM  2'h2

`define AHX_TR_IDLE    2'h0
`define AHX_TR_NONSEQ  2'h2
`define AHX_TR_SEQ     2'h3
`define AHX_BURST_SGL  3'h0
`define AHX_BURST_INCR 3'h1

`define AHX_RST_PRIO   1'h0
`define AHX_OWN_CPU    1'h0
`define AHX_OWN_DMA    1'h1

`endif

// ===== include/ahx_pkg.sv
// types shared by the bus fabric modules
package ahx_pkg;

  typedef struct packed {
    logic [1:0]  trans;
    logic [31:0] addr;
    logic        write;
    logic [2:0]  size;
    logic [2:0]  burst;
    logic        lock;
    logic [31:0] wdata;
  } ahx_req_s;

  typedef enum logic [3:0] {
    SLV_ROM    = 4'h0,
    SLV_OTPREG = 4'h1,
    SLV_OTPCEL = 4'h2,
    SLV_RAM1   = 4'h3,
    SLV_RAM2   = 4'h4,
    SLV_RAM3   = 4'h5,
    SLV_LINK   = 4'h6,
    SLV_RADIO  = 4'h7,
    SLV_APBN   = 4'h8,
    SLV_APBW   = 4'h9
  } ahx_slv_e;

  typedef enum logic [1:0] {
    DOM_SYSTEM = 2'h0,
    DOM_RADIO  = 2'h1,
    DOM_SLEEP  = 2'h2,
    DOM_TIMER  = 2'h3
  } ahx_dom_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10,
    ST_RESP = 2'b11
  } ahx_state_e;

  typedef struct packed {
    logic        hit;
    ahx_slv_e    slv;
    ahx_dom_e    dom;
    logic [31:0] offset;
  } ahx_dec_s;

  // domain in which a slave port's own bus outputs live
  function automatic ahx_dom_e ahx_slv_dom(input ahx_slv_e s);
    case (s)
      SLV_LINK, SLV_RADIO: ahx_slv_dom = DOM_RADIO;
      SLV_APBW:            ahx_slv_dom = DOM_TIMER;
      default:             ahx_slv_dom = DOM_SYSTEM;
    endcase
  endfunction : ahx_slv_dom

endpackage : ahx_pkg

// ===== core/ahx_addr_decode.sv
// address decoder of the bus fabric with low region remap
`timescale 1ns/1ns
`default_nettype none
`include "ahx_defs.svh"

module ahx_addr_decode (
  input  wire logic [31:0]     addr_i,
  input  wire logic [1:0]      remap_i,
  output var ahx_pkg::ahx_dec_s dec_o
);

  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_rng = (a >= lo) && (a < hi);
  endfunction : in_rng

  logic [31:0] eff;
  logic [31:0] base;

  always_comb begin
    eff = addr_i;
    if (addr_i < `AHX_ZERO_HI) begin
      case (remap_i)
        `AHX_REMAP_OTP: eff = addr_i + `AHX_OTPC_LO;
        `AHX_REMAP_RAM: eff = addr_i + `AHX_RAM1_LO;
        default:        eff = addr_i + `AHX_ROM_LO;
      endcase
    end
  end

  // a remapped access past the end of its target falls into a hole and errors unless it reaches a higher region
  always_comb begin
    base          = eff;
    dec_o.hit     = 1'b1;
    dec_o.slv     = ahx_pkg::SLV_ROM;
    dec_o.dom     = ahx_pkg::DOM_SYSTEM;
    if (in_rng(eff, `AHX_ROM_LO, `AHX_ROM_HI)) begin
      base = `AHX_ROM_LO;
    end else if (in_rng(eff, `AHX_OTPR_LO, `AHX_OTPR_HI)) begin
      dec_o.slv = ahx_pkg::SLV_OTPREG;
      base      = `AHX_OTPR_LO;
    end else if (in_rng(eff, `AHX_OTPC_LO, `AHX_OTPC_HI)) begin
      dec_o.slv = ahx_pkg::SLV_OTPCEL;
      base      = `AHX_OTPC_LO;
    end else if (in_rng(eff, `AHX_RAM1_LO, `AHX_RAM2_LO)) begin
      dec_o.slv = ahx_pkg::SLV_RAM1;
      base      = `AHX_RAM1_LO;
    end else if (in_rng(eff, `AHX_RAM2_LO, `AHX_RAM3_LO)) begin
      dec_o.slv = ahx_pkg::SLV_RAM2;
      base      = `AHX_RAM2_LO;
    end else if (in_rng(eff, `AHX_RAM3_LO, `AHX_RAM3_LAST + 32'h1)) begin
      dec_o.slv = ahx_pkg::SLV_RAM3;
      base      = `AHX_RAM3_LO;
    end else if (in_rng(eff, `AHX_LINK_LO, `AHX_RADIO_LO)) begin
      dec_o.slv = ahx_pkg::SLV_LINK;
      dec_o.dom = ahx_pkg::DOM_RADIO;
      base      = `AHX_LINK_LO;
    end else if (in_rng(eff, `AHX_RADIO_LO, `AHX_RADIO_HI)) begin
      dec_o.slv = ahx_pkg::SLV_RADIO;
      dec_o.dom = ahx_pkg::DOM_RADIO;
      base      = `AHX_RADIO_LO;
    end else if (in_rng(eff, `AHX_PMU_LO, `AHX_QDEC_HI)) begin
      dec_o.slv = ahx_pkg::SLV_APBN;
      dec_o.dom = ahx_pkg::DOM_SLEEP;
      base      = `AHX_PMU_LO;
    end else if (in_rng(eff, `AHX_SYSP_LO, `AHX_SYSP_HI)) begin
      dec_o.slv = ahx_pkg::SLV_APBN;
      base      = `AHX_PMU_LO;
    end else if (in_rng(eff, `AHX_WIDE_LO, `AHX_WIDE_HI)) begin
      dec_o.slv = ahx_pkg::SLV_APBW;
      dec_o.dom = ahx_pkg::DOM_TIMER;
      base      = `AHX_WIDE_LO;
    end else begin
      dec_o.hit = 1'b0;
    end
    dec_o.offset = eff - base;
  end

endmodule : ahx_addr_decode
`default_nettype wire

// ===== core/ahx_fabric.sv
// two-master arbiter and slave router of the system bus
`timescale 1ns/1ns
`default_nettype none
`include "ahx_defs.svh"

module ahx_fabric #(
  parameter int NUM_SLV = `AHX_NUM_SLV
) (
  input  wire logic                    CLK_SYS_I,
  input  wire logic                    RST_B_I,
  input  wire logic                    PRIO_SEL_I,
  input  wire logic [1:0]              REMAP_SEL_I,
  input  wire logic [3:0]              DOM_ON_I,
  input  wire ahx_pkg::ahx_req_s       CPU_REQ_I,
  input  wire ahx_pkg::ahx_req_s       DMA_REQ_I,
  output logic                         CPU_READY_O,
  output logic                         CPU_RESP_O,
  output logic [31:0]                  CPU_RDATA_O,
  output logic                         DMA_READY_O,
  output logic                         DMA_RESP_O,
  output logic [31:0]                  DMA_RDATA_O,
  output logic                         CPU_GRANT_O,
  output logic                         DMA_GRANT_O,
  output logic [NUM_SLV-1:0]           S_HSEL_O,
  output logic [31:0]                  S_HADDR_O,
  output logic [1:0]                   S_HTRANS_O,
  output logic                         S_HWRITE_O,
  output logic [2:0]                   S_HSIZE_O,
  output logic [2:0]                   S_HBURST_O,
  output logic                         S_HMASTLOCK_O,
  output logic [31:0]                  S_HWDATA_O,
  output logic                         S_HREADY_O,
  output logic                         S_HMASTER_O,
  input  wire logic [NUM_SLV-1:0][31:0] S_HRDATA_I,
  input  wire logic [NUM_SLV-1:0]      S_HREADYOUT_I,
  input  wire logic [NUM_SLV-1:0]      S_HRESP_I
);

  logic rst_q1;
  logic rst_n;

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // isolation clamps: a dark slave looks ready, okay and silent
  logic [NUM_SLV-1:0]       iso_rdy;
  logic [NUM_SLV-1:0]       iso_resp;
  logic [NUM_SLV-1:0][31:0] iso_rdata;

  for (genvar i = 0; i < NUM_SLV; i++) begin : g_iso
    logic on;
    assign on           = DOM_ON_I[ahx_pkg::ahx_slv_dom(ahx_pkg::ahx_slv_e'(i))];
    assign iso_rdy[i]   = on ? S_HREADYOUT_I[i] : 1'b1;
    assign iso_resp[i]  = on ? S_HRESP_I[i] : 1'b0;
    assign iso_rdata[i] = on ? S_HRDATA_I[i] : 32'h0;
  end

  ahx_pkg::ahx_state_e state, next_state;
  logic                owner, next_owner;
  logic                prio, next_prio;
  logic                lock, next_lock;
  logic [4:0]          beats, next_beats;
  logic [3:0]          sel, next_sel;
  logic                cpu_ready, next_cpu_ready;
  logic                dma_ready, next_dma_ready;
  logic                resp, next_resp;
  logic [31:0]         rdata, next_rdata;
  logic [NUM_SLV-1:0]  hsel, next_hsel;
  ahx_pkg::ahx_req_s   cur, next_cur;
  logic                hready, next_hready;
  logic [1:0]          htrans, next_htrans;
  logic                cpu_grant, next_cpu_grant;

  ahx_pkg::ahx_req_s   win_req;
  ahx_pkg::ahx_dec_s   dec;
  logic                win, take, hold, cpu_rq, dma_rq, acc, dom_ok;

  assign cpu_rq  = CPU_REQ_I.trans[1];
  assign dma_rq  = DMA_REQ_I.trans[1];
  assign hold    = lock || (beats != 5'h0);
  assign win_req = win ? DMA_REQ_I : CPU_REQ_I;
  assign acc     = (state == ahx_pkg::ST_IDLE) && take;
  assign dom_ok  = DOM_ON_I[dec.dom];

  ahx_addr_decode u_decode (
    .addr_i  (win_req.addr),
    .remap_i (REMAP_SEL_I),
    .dec_o   (dec)
  );

  function automatic logic [4:0] burst_beats(input logic [2:0] b);
    case (b[2:1])
      2'h1:    burst_beats = 5'h3;
      2'h2:    burst_beats = 5'h7;
      2'h3:    burst_beats = 5'hf;
      default: burst_beats = 5'h0;
    endcase
  endfunction : burst_beats

  always_comb begin
    win  = owner;
    take = 1'b0;
    if (hold) begin
      take = owner ? dma_rq : cpu_rq;
    end else if (cpu_rq && dma_rq) begin
      win  = prio;
      take = 1'b1;
    end else if (cpu_rq || dma_rq) begin
      win  = dma_rq ? `AHX_OWN_DMA : `AHX_OWN_CPU;
      take = 1'b1;
    end
  end

  always_comb begin
    next_state     = state;
    next_owner     = owner;
    next_prio      = PRIO_SEL_I;
    next_lock      = lock;
    next_beats     = beats;
    next_sel       = sel;
    next_cpu_ready = 1'b0;
    next_dma_ready = 1'b0;
    next_resp      = resp;
    next_rdata     = rdata;
    next_hsel      = '0;
    next_cur       = cur;
    next_hready    = 1'b1;
    next_htrans    = `AHX_TR_IDLE;
    unique case (state)
      ahx_pkg::ST_IDLE: begin
        if (take) begin
          next_owner = win;
          next_lock  = win_req.lock;
          if (win_req.trans == `AHX_TR_NONSEQ) begin
            next_beats = burst_beats(win_req.burst);
          end else if (beats != 5'h0) begin
            next_beats = beats - 5'h1;
          end
          next_cur       = win_req;
          next_cur.addr  = dec.offset;
          next_cur.trans = `AHX_TR_NONSEQ;
          next_sel       = dec.slv;
          if (dec.hit && dom_ok) begin
            next_hsel[dec.slv] = 1'b1;
            next_htrans        = `AHX_TR_NONSEQ;
            next_state         = ahx_pkg::ST_ADDR;
          end else begin
            next_resp      = 1'b1;
            next_rdata     = 32'h0;
            next_cpu_ready = !win;
            next_dma_ready = win;
            next_state     = ahx_pkg::ST_RESP;
          end
        end else if (!lock && beats != 5'h0) begin
          next_beats = 5'h0; // owner left the burst early
        end
      end
      ahx_pkg::ST_ADDR: begin
        next_hready = iso_rdy[sel];
        next_state  = ahx_pkg::ST_DATA;
      end
      ahx_pkg::ST_DATA: begin
        next_hready = iso_rdy[sel];
        if (iso_rdy[sel]) begin
          next_resp      = iso_resp[sel];
          next_rdata     = iso_rdata[sel];
          next_cpu_ready = !owner;
          next_dma_ready = owner;
          next_hready    = 1'b1;
          next_state     = ahx_pkg::ST_RESP;
        end
      end
      ahx_pkg::ST_RESP: begin
        next_state = ahx_pkg::ST_IDLE;
      end
    endcase
    next_cpu_grant = !next_owner;
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ahx_pkg::ST_IDLE;
      owner     <= `AHX_OWN_CPU;
      prio      <= `AHX_RST_PRIO;
      lock      <= 1'b0;
      beats     <= 5'h0;
      sel       <= 4'h0;
      cpu_ready <= 1'b0;
      dma_ready <= 1'b0;
      resp      <= 1'b0;
      rdata     <= 32'h0;
      hsel      <= '0;
      cur       <= '0;
      hready    <= 1'b1;
      htrans    <= `AHX_TR_IDLE;
      cpu_grant <= 1'b1;
    end else begin
      state     <= next_state;
      owner     <= next_owner;
      prio      <= next_prio;
      lock      <= next_lock;
      beats     <= next_beats;
      sel       <= next_sel;
      cpu_ready <= next_cpu_ready;
      dma_ready <= next_dma_ready;
      resp      <= next_resp;
      rdata     <= next_rdata;
      hsel      <= next_hsel;
      cur       <= next_cur;
      hready    <= next_hready;
      htrans    <= next_htrans;
      cpu_grant <= next_cpu_grant;
    end
  end

  // slave side sees a nonseq address phase only while a select is up
  assign S_HSEL_O      = hsel;
  assign S_HADDR_O     = cur.addr;
  assign S_HTRANS_O    = htrans;
  assign S_HWRITE_O    = cur.write;
  assign S_HSIZE_O     = cur.size;
  assign S_HBURST_O    = cur.burst;
  assign S_HMASTLOCK_O = cur.lock;
  assign S_HWDATA_O    = cur.wdata;
  assign S_HREADY_O    = hready;
  assign S_HMASTER_O   = owner;
  // grant kept in its own flop so the pin has no inverter behind it
  assign CPU_GRANT_O   = cpu_grant;
  assign DMA_GRANT_O   = owner;
  assign CPU_READY_O   = cpu_ready;
  assign DMA_READY_O   = dma_ready;
  assign CPU_RESP_O    = resp;
  assign DMA_RESP_O    = resp;
  assign CPU_RDATA_O   = rdata;
  assign DMA_RDATA_O   = rdata;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!rst_n);

  sequence accept_s;
    acc && dec.hit && dom_ok;
  endsequence

  sequence miss_s;
    acc && !(dec.hit && dom_ok);
  endsequence

  grant_onehot_a: assert property ($onehot({CPU_GRANT_O, DMA_GRANT_O}))
    else $error("bus granted to none or both masters");

  prio_winner_a: assert property (acc && !hold && cpu_rq && dma_rq |=> owner == $past(prio))
    else $error("contention not resolved by priority select");

  slave_addr_a: assert property (|S_HSEL_O |-> S_HTRANS_O == `AHX_TR_NONSEQ && state == ahx_pkg::ST_ADDR)
    else $error("slave selected outside an address phase");

  rom_select_a: assert property (accept_s and (dec.slv == ahx_pkg::SLV_ROM) |=> S_HSEL_O[0])
    else $error("rom region did not select rom");

  ram_bank_a: assert property (acc && win_req.addr >= `AHX_RAM2_LO && win_req.addr < `AHX_RAM3_LO && dom_ok
                               |=> S_HSEL_O[ahx_pkg::SLV_RAM2] && S_HADDR_O < 32'h0000_3000)
    else $error("second ram bank not selected");

  narrow_bus_a: assert property (acc && win_req.addr >= `AHX_PMU_LO && win_req.addr < `AHX_QDEC_HI && dom_ok
                                 |=> S_HSEL_O[ahx_pkg::SLV_APBN])
    else $error("sleep domain register not on narrow bridge");

  miss_error_a: assert property (miss_s |=> S_HSEL_O == '0 ##0 (CPU_READY_O || DMA_READY_O) && resp ##1 !CPU_READY_O)
    else $error("unmapped access not answered with error");

  lock_hold_a: assert property (state == ahx_pkg::ST_IDLE && lock && !take |=> $stable(owner))
    else $error("ownership moved inside a locked sequence");

  dark_slave_a: assert property (|S_HSEL_O |-> DOM_ON_I[ahx_pkg::ahx_slv_dom(ahx_pkg::ahx_slv_e'(sel))])
    else $error("slave selected in a powered-down domain");

  done_latency_a: assert property (accept_s ##2 (state == ahx_pkg::ST_DATA && iso_rdy[sel])
                                   |=> (CPU_READY_O || DMA_READY_O))
    else $error("ready pulse missing after slave completion");

  ready_owner_a: assert property (!(CPU_READY_O && !CPU_GRANT_O) && !(DMA_READY_O && !DMA_GRANT_O))
    else $error("ready pulse sent to a master without the grant");

  remap_zero_a: assert property (acc && win_req.addr < (`AHX_RAM2_LO - `AHX_RAM1_LO) && dom_ok
                                 && REMAP_SEL_I == `AHX_REMAP_RAM
                                 |=> S_HSEL_O[ahx_pkg::SLV_RAM1] && S_HADDR_O == $past(win_req.addr))
    else $error("low region not remapped onto the first ram bank");

  wide_bus_a: assert property (acc && win_req.addr >= `AHX_WIDE_LO && win_req.addr < `AHX_WIDE_HI && dom_ok
                               |=> S_HSEL_O[ahx_pkg::SLV_APBW])
    else $error("timer domain register not on wide bridge");

endmodule : ahx_fabric
`default_nettype wire

// ===== verification/ahx_slave_model.sv
// responder standing in for all ten slaves behind the fabric
`timescale 1ns/1ns
`default_nettype none
module ahx_slave_model (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [9:0]  hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hready_i,
  input  wire logic [3:0]  wait_i,
  input  wire logic [3:0]  err_idx_i,
  output logic [9:0][31:0] hrdata_o,
  output logic [9:0]       hreadyout_o,
  output logic [9:0]       hresp_o
);
  logic        busy;
  logic [3:0]  idx;
  logic [3:0]  cnt;
  logic [31:0] data;
  logic [3:0]  hit_idx;

  always_comb begin
    hit_idx = 4'h0;
    for (int i = 0; i < 10; i++) if (hsel_i[i]) hit_idx = 4'(i);
  end

  // read data names the slave and the offset, so a misroute shows in the value
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy <= 1'b0;
      idx  <= 4'h0;
      cnt  <= 4'h0;
      data <= 32'h0;
    end else if (busy) begin
      if (cnt == 4'h0) busy <= 1'b0;
      else cnt <= cnt - 4'h1;
    end else if (|hsel_i && htrans_i[1] && hready_i) begin
      busy <= 1'b1;
      idx  <= hit_idx;
      cnt  <= wait_i;
      data <= {hit_idx, haddr_i[27:0]};
    end
  end

  // idle slaves show the inverse so a stale value is never mistaken for an answer
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      hreadyout_o[i] = !(busy && idx == 4'(i) && cnt != 4'h0);
      hresp_o[i]     = busy && idx == 4'(i) && err_idx_i == 4'(i);
      hrdata_o[i]    = (busy && idx == 4'(i)) ? data : ~data;
    end
  end
endmodule : ahx_slave_model
`default_nettype wire

// ===== verification/tb_ahb_arbiter_address_decoder.sv
// self-checking bench of the two-master bus fabric
`timescale 1ns/1ns
`default_nettype none
module tb_ahb_arbiter_address_decoder;
  logic              clk_sys, rst_b, prio_sel;
  logic [1:0]        remap;
  logic [3:0]        dom_on, wait_n, err_idx;
  ahx_pkg::ahx_req_s cpu_req, dma_req;
  logic [1:0]        rdy, rsp, grant;
  logic [31:0]       rd [2];
  logic [9:0]        s_hsel, s_hrdy, s_hresp, sel_seen;
  logic [9:0][31:0]  s_hrdata;
  logic [31:0]       s_haddr, s_hwdata, adr_seen, wd_seen;
  logic [1:0]        s_htrans;
  logic [8:0]        ctl_seen;
  logic [2:0]        s_hsize, s_hburst;
  logic              s_hwrite, s_hlock, s_hready, s_hmaster;
  int                fails, check_count;
  logic [31:0]       bs [10] = '{32'h07f00000, 32'h07f40000, 32'h07f80000, 32'h07fc0000, 32'h07fc4000,
                                 32'h07fc7000, 32'h40000000, 32'h40001000, 32'h50000000, 32'h50004000};

  ahx_fabric dut (
    .CLK_SYS_I(clk_sys), .RST_B_I(rst_b), .PRIO_SEL_I(prio_sel), .REMAP_SEL_I(remap), .DOM_ON_I(dom_on),
    .CPU_REQ_I(cpu_req), .DMA_REQ_I(dma_req), .CPU_READY_O(rdy[0]), .CPU_RESP_O(rsp[0]),
    .CPU_RDATA_O(rd[0]), .DMA_READY_O(rdy[1]), .DMA_RESP_O(rsp[1]), .DMA_RDATA_O(rd[1]),
    .CPU_GRANT_O(grant[0]), .DMA_GRANT_O(grant[1]), .S_HSEL_O(s_hsel), .S_HADDR_O(s_haddr),
    .S_HTRANS_O(s_htrans), .S_HWRITE_O(s_hwrite), .S_HSIZE_O(s_hsize), .S_HBURST_O(s_hburst),
    .S_HMASTLOCK_O(s_hlock), .S_HWDATA_O(s_hwdata), .S_HREADY_O(s_hready), .S_HMASTER_O(s_hmaster),
    .S_HRDATA_I(s_hrdata), .S_HREADYOUT_I(s_hrdy), .S_HRESP_I(s_hresp));

  ahx_slave_model slaves (
    .clk_i(clk_sys), .rst_b_i(rst_b), .hsel_i(s_hsel), .haddr_i(s_haddr), .htrans_i(s_htrans),
    .hready_i(s_hready), .wait_i(wait_n), .err_idx_i(err_idx), .hrdata_o(s_hrdata),
    .hreadyout_o(s_hrdy), .hresp_o(s_hresp));

  always #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (|s_hsel) begin
      sel_seen <= s_hsel;
      adr_seen <= s_haddr;
      wd_seen  <= s_hwdata;
      ctl_seen <= {s_hmaster, s_hwrite, s_hlock, s_hsize, s_hburst};
    end
  end

  always @(negedge clk_sys) if (rst_b === 1'b1) chk(32'(^grant), 32'h1);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  // request held until the edge that sees ready; n counts falling edges up to it
  task automatic go(input int m, input logic [31:0] a, input logic wr, input logic lk,
                    output logic rs, output logic [31:0] d, output int n);
    ahx_pkg::ahx_req_s r;
    r = '{trans: 2'h2, addr: a, write: wr, size: 3'h2, burst: 3'h0, lock: lk, wdata: ~a};
    n = 0;
    @(posedge clk_sys);
    if (m == 1) dma_req <= r;
    else cpu_req <= r;
    do begin
      @(negedge clk_sys);
      n++;
    end while (rdy[m] !== 1'b1 && n < 40);
    if (n >= 40) begin
      fails++;
      summarize();
    end
    rs = rsp[m];
    d  = rd[m];
    @(posedge clk_sys);
    if (m == 1) dma_req.trans <= 2'h0;
    else cpu_req.trans <= 2'h0;
  endtask : go

  // idx 4'hf means the address must be refused
  task automatic xfer(input int m, input logic [31:0] a, input logic [3:0] idx, input logic [31:0] base);
    logic        rs;
    logic [31:0] d, off;
    int          n;
    off      = a - base;
    sel_seen = '0;
    go(m, a, 1'b0, 1'b0, rs, d, n);
    if (idx == 4'hf) begin
      chk(32'(rs), 32'h1);
      chk(d, 32'h0);
      chk(32'(sel_seen), 32'h0);
      chk(32'(n), 32'h2);
    end else begin
      chk(32'(rs), 32'h0);
      chk(d, {idx, off[27:0]});
      chk(32'(sel_seen), 32'(10'h1 << idx));
      chk(adr_seen, off);
      chk(32'(n), 32'(4 + wait_n));
      chk(32'(ctl_seen), 32'({1'(m), 2'h0, 3'h2, 3'h0}));
    end
  endtask : xfer

  task automatic t_map;
    logic [31:0] ad [25] = '{32'h07f00000, 32'h07f23ffc, 32'h07f24000, 32'h07f40000, 32'h07f400fc,
      32'h07f40100, 32'h07f80000, 32'h07f87ffc, 32'h07f88000, 32'h07fc0000, 32'h07fc3ffc, 32'h07fc4000,
      32'h07fc6ffc, 32'h07fc7000, 32'h07fcbffc, 32'h07fcc000, 32'h40000000, 32'h40001000, 32'h40003ffc,
      32'h40004000, 32'h50000000, 32'h50000100, 32'h50000200, 32'h50000300, 32'h50004000};
    logic [3:0] ix [25] = '{0, 0, 15, 1, 1, 15, 2, 2, 15, 3, 3, 4, 4, 5, 5, 15, 6, 7, 7, 15, 8, 8, 8, 15, 9};
    for (int i = 0; i < 25; i++) xfer(i % 2, ad[i], ix[i], bs[ix[i] % 10]);
    xfer(0, 32'h04000000, 4'hf, 32'h0);
    $display("test map done");
  endtask : t_map

  task automatic t_remap;
    logic [3:0] ri [4] = '{0, 2, 3, 0};
    for (int r = 0; r < 4; r++) begin
      remap <= 2'(r);
      repeat (3) @(posedge clk_sys);
      xfer(r % 2, 32'h00000100, ri[r], 32'h0);
    end
    remap <= 2'h1;
    repeat (3) @(posedge clk_sys);
    xfer(0, 32'h00008000, 4'hf, 32'h0);
    remap <= 2'h0;
    $display("test remap done");
  endtask : t_remap

  task automatic t_dark;
    logic [3:0] dm [3] = '{4'hd, 4'h7, 4'hb};
    logic [31:0] da [3] = '{32'h40000000, 32'h50004000, 32'h50000100};
    for (int i = 0; i < 3; i++) begin
      dom_on <= dm[i];
      repeat (2) @(posedge clk_sys);
      xfer(1, da[i], 4'hf, 32'h0);
    end
    dom_on <= 4'hf;
    xfer(1, 32'h40000000, 4'h6, 32'h40000000);
    $display("test dark done");
  endtask : t_dark

  task automatic t_wait;
    logic        rs;
    logic [31:0] d;
    int          n;
    wait_n <= 4'h3;
    xfer(0, 32'h07fc4010, 4'h4, 32'h07fc4000);
    go(1, 32'h07fc7020, 1'b1, 1'b0, rs, d, n);
    chk(wd_seen, ~32'h07fc7020);
    chk(32'(ctl_seen), 32'({1'b1, 1'b1, 1'b0, 3'h2, 3'h0}));
    wait_n  <= 4'h0;
    err_idx <= 4'h5;
    go(0, 32'h07fc7000, 1'b0, 1'b0, rs, d, n);
    chk(32'(rs), 32'h1);
    err_idx <= 4'hf;
    $display("test wait done");
  endtask : t_wait

  // both masters request at one edge; lock=1 leaves a locked transfer first
  task automatic t_arb(input logic p, input logic lk);
    logic        r0, r1;
    logic [31:0] d0, d1;
    time         tc, td;
    int          n;
    prio_sel <= p;
    if (lk) begin
      go(1, 32'h07fc4000, 1'b0, 1'b1, r1, d1, n);
      chk(32'(ctl_seen[6]), 32'h1);
    end
    repeat (3) @(posedge clk_sys);
    fork
      begin go(0, 32'h07fc0004, 1'b0, 1'b0, r0, d0, n); tc = $time; end
      begin go(1, 32'h07fc4008, 1'b0, 1'b0, r1, d1, n); td = $time; end
    join
    chk(32'(tc < td), 32'(!p && !lk));
    chk(d0, 32'h30000004);
    chk(d1, 32'h40000008);
    $display("test arbitration done");
  endtask : t_arb

  initial begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    prio_sel = 1'b0;
    remap = 2'h0;
    dom_on = 4'hf;
    wait_n = 4'h0;
    err_idx = 4'hf;
    cpu_req = '0;
    dma_req = '0;
    sel_seen = '0;
    fails = 0;
    check_count = 0;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(32'(grant), 32'h1);
    t_map();
    t_remap();
    t_dark();
    t_wait();
    t_arb(1'b0, 1'b0);
    t_arb(1'b1, 1'b0);
    t_arb(1'b0, 1'b1);
    summarize();
  end
endmodule : tb_ahb_arbiter_address_decoder
`default_nettype wire
